/* File: hw/cpu_model_config_regs.sv */
// model-specific configuration registers reached by register read/write instructions
// assumes requests come from logic on clk; one request per cycle
`timescale 1ns/1ns
module cpu_model_config_regs #(
	parameter logic [63:0] RANGE_CAP_VALUE = 64'h0 // capability word, plain default
) (
	input  wire logic                    clk,
	input  wire logic                    reset,
	input  wire cfg_regs_pkg::reg_req_t  req,
	input  wire cfg_regs_pkg::ident_req_t ident,
	input  wire logic                    update_loaded,
	input  wire logic [31:0]             update_signature_in,
	output cfg_regs_pkg::reg_rsp_t       rsp,
	output logic                         update_load_start,
	output logic [2:0]                   bus_speed,
	output logic                         serial_number_disable
);
	import cfg_regs_pkg::*;

	//------------------------------------------------------------
	// register state
	//------------------------------------------------------------
	logic [2:0]        bus_speed_reg;
	logic [2:0]        bus_speed_next;
	logic [31:0]       sig_reg;
	logic [31:0]       sig_next;
	logic              trig_reg;
	logic              trig_next;
	reg_rsp_t          rsp_reg;
	reg_rsp_t          rsp_next;
	logic              sn_dis;
	logic              sn_set_req;
	logic              wr;
	logic              rd;

	assign wr = req.valid & req.write;
	assign rd = req.valid & ~req.write;

	// only writing a one reaches the bit; a zero write is dropped
	assign sn_set_req = wr && (req.addr == ADDR_MISC_CTL) && req.wdata[SN_DIS_BIT];

	set_once_bit u_sn_dis (
		.clk     (clk),
		.reset   (reset),
		.set_req (sn_set_req),
		.q       (sn_dis)
	);

	//------------------------------------------------------------
	// next-state logic
	//------------------------------------------------------------
	always_comb begin
		bus_speed_next = bus_speed_reg;
		sig_next       = sig_reg;
		trig_next      = 1'b0;
		rsp_next       = '0;
		if (wr) begin
			case (req.addr)
				ADDR_FREQ_CFG: begin
					bus_speed_next = req.wdata[BUS_SPEED_HI:BUS_SPEED_LO];
				end
				ADDR_UPD_TRIG: begin
					trig_next = 1'b1;
				end
				ADDR_UPD_SIG: begin
					sig_next = req.wdata[SIG_HI:SIG_LO];
				end
				default: begin
				end
			endcase
		end
		// identification refresh lands after any write in the same cycle
		if (ident.valid && ident.accumulator == IDENT_LEAF_ONE) begin
			sig_next = update_loaded ? update_signature_in : SIG_NONE;
		end
		if (rd) begin
			rsp_next.valid = 1'b1;
			case (req.addr)
				ADDR_FREQ_CFG: begin
					rsp_next.rdata[BUS_SPEED_HI:BUS_SPEED_LO] = bus_speed_reg;
				end
				ADDR_UPD_SIG: begin
					rsp_next.rdata[SIG_HI:SIG_LO] = sig_reg;
				end
				ADDR_RANGE_CAP: begin
					rsp_next.rdata = RANGE_CAP_VALUE;
				end
				ADDR_MISC_CTL: begin
					rsp_next.rdata[SN_DIS_BIT] = sn_dis;
				end
				default: begin
					rsp_next.rdata = ZERO64; // trigger and unmapped read zero
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			bus_speed_reg <= BUS_SPEED_100MHZ;
			sig_reg       <= SIG_NONE;
			trig_reg      <= 1'b0;
			rsp_reg       <= '0;
		end else begin
			bus_speed_reg <= bus_speed_next;
			sig_reg       <= sig_next;
			trig_reg      <= trig_next;
			rsp_reg       <= rsp_next;
		end
	end

	assign rsp                   = rsp_reg;
	assign update_load_start     = trig_reg;
	assign bus_speed             = bus_speed_reg;
	assign serial_number_disable = sn_dis;

	//------------------------------------------------------------
	// assertions
	//------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_bus_speed_write;
		wr && req.addr == ADDR_FREQ_CFG |=> bus_speed == $past(req.wdata[BUS_SPEED_HI:BUS_SPEED_LO]);
	endproperty
	a_bus_speed_write: assert property (p_bus_speed_write) else $error("bus speed not taken");

	property p_trig_pulse;
		wr && req.addr == ADDR_UPD_TRIG |=> update_load_start;
	endproperty
	property p_trig_cause;
		update_load_start |-> $past(wr) && $past(req.addr) == ADDR_UPD_TRIG;
	endproperty
	a_trig_pulse: assert property (p_trig_pulse) else $error("trigger pulse missing");
	a_trig_cause: assert property (p_trig_cause) else $error("trigger without write");

	property p_sig_loaded;
		ident.valid && ident.accumulator == IDENT_LEAF_ONE && update_loaded
			##1 (rd && req.addr == ADDR_UPD_SIG && !ident.valid && !wr)
			|=> rsp.valid && rsp.rdata[SIG_HI:SIG_LO] == $past(update_signature_in, 2);
	endproperty
	a_sig_loaded: assert property (p_sig_loaded) else $error("signature not reported");

	property p_sig_none;
		ident.valid && ident.accumulator == IDENT_LEAF_ONE && !update_loaded
			##1 (rd && req.addr == ADDR_UPD_SIG && !ident.valid)
			|=> rsp.rdata == ZERO64;
	endproperty
	a_sig_none: assert property (p_sig_none) else $error("signature not zero");

	property p_sn_set;
		wr && req.addr == ADDR_MISC_CTL && req.wdata[SN_DIS_BIT] |=> serial_number_disable;
	endproperty
	a_sn_set: assert property (p_sn_set) else $error("serial disable not set");

	property p_sn_sticky;
		serial_number_disable |=> serial_number_disable [*8];
	endproperty
	a_sn_sticky: assert property (p_sn_sticky) else $error("serial disable cleared");

	property p_freq_read;
		rd && req.addr == ADDR_FREQ_CFG |=> rsp.valid && rsp.rdata == (64'($past(bus_speed)) << BUS_SPEED_LO);
	endproperty
	a_freq_read: assert property (p_freq_read) else $error("freq read wrong");

	property p_misc_reserved;
		rd && req.addr == ADDR_MISC_CTL |=> (rsp.rdata & ~(64'h1 << SN_DIS_BIT)) == ZERO64;
	endproperty
	a_misc_reserved: assert property (p_misc_reserved) else $error("reserved bits set");

	//------------------------------------------------------------
	// answer timing and hold checks
	//------------------------------------------------------------
	// a read answers exactly once; idle cycles must show zero data
	property p_read_answer;
		rd |=> rsp.valid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");

	property p_rsp_idle;
		!rd |=> !rsp.valid && rsp.rdata == ZERO64;
	endproperty
	a_rsp_idle: assert property (p_rsp_idle) else $error("answer without read");

	property p_unmapped_read;
		rd && req.addr != ADDR_FREQ_CFG && req.addr != ADDR_UPD_SIG && req.addr != ADDR_RANGE_CAP
			&& req.addr != ADDR_MISC_CTL |=> rsp.rdata == ZERO64;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

	property p_range_cap_read;
		rd && req.addr == ADDR_RANGE_CAP |=> rsp.rdata == RANGE_CAP_VALUE;
	endproperty
	a_range_cap_read: assert property (p_range_cap_read) else $error("capability word altered");

	property p_bus_speed_hold;
		!(wr && req.addr == ADDR_FREQ_CFG) |=> $stable(bus_speed);
	endproperty
	a_bus_speed_hold: assert property (p_bus_speed_hold) else $error("bus speed changed without write");

	// other identification leaves must not disturb a loaded signature
	property p_sig_other_leaf;
		ident.valid && ident.accumulator != IDENT_LEAF_ONE && !(wr && req.addr == ADDR_UPD_SIG) |=> $stable(sig_reg);
	endproperty
	a_sig_other_leaf: assert property (p_sig_other_leaf) else $error("signature disturbed");

	property p_trig_drop;
		update_load_start && !(wr && req.addr == ADDR_UPD_TRIG) |=> !update_load_start;
	endproperty
	a_trig_drop: assert property (p_trig_drop) else $error("trigger pulse too long");

	c_trigger:    cover property (wr && req.addr == ADDR_UPD_TRIG ##1 update_load_start);
	c_sig_report: cover property (ident.valid && update_loaded ##[1:4] rsp.valid);
	c_sn_clear_try: cover property (serial_number_disable && wr && req.addr == ADDR_MISC_CTL && !req.wdata[SN_DIS_BIT]);
	c_other_leaf: cover property (ident.valid && ident.accumulator != IDENT_LEAF_ONE);
	c_speed_rsvd: cover property (wr && req.addr == ADDR_FREQ_CFG
		&& req.wdata[BUS_SPEED_HI:BUS_SPEED_LO] != BUS_SPEED_100MHZ);
endmodule : cpu_model_config_regs

/* File: hw/cfg_regs_pkg.sv */
// package for the model-specific configuration register group
// assumes one clock, synchronous active-high reset, same-domain requests
package cfg_regs_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 64;

	// register addresses
	localparam logic [ADDR_W-1:0] ADDR_FREQ_CFG   = 12'h02C;
	localparam logic [ADDR_W-1:0] ADDR_UPD_TRIG   = 12'h079;
	localparam logic [ADDR_W-1:0] ADDR_UPD_SIG    = 12'h08B;
	localparam logic [ADDR_W-1:0] ADDR_RANGE_CAP  = 12'h0FE;
	localparam logic [ADDR_W-1:0] ADDR_MISC_CTL   = 12'h119;

	// field positions
	localparam int BUS_SPEED_LO = 21;
	localparam int BUS_SPEED_HI = 23;
	localparam int SIG_LO       = 32;
	localparam int SIG_HI       = 63;
	localparam int SN_DIS_BIT   = 21;

	// reset values and encodings
	localparam logic [2:0]  BUS_SPEED_100MHZ = 3'h0;
	localparam logic [31:0] SIG_NONE         = 32'h0;
	localparam logic [DATA_W-1:0] ZERO64     = 64'h0;
	localparam logic [31:0] IDENT_LEAF_ONE   = 32'h1;

	typedef struct packed {
		logic              valid;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic              valid;
		logic [DATA_W-1:0] rdata;
	} reg_rsp_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] accumulator;
	} ident_req_t;
endpackage : cfg_regs_pkg

/* File: hw/set_once_bit.sv */
// a single bit that software may set but never clear
// assumes reset is synchronous and the only way back to zero
`timescale 1ns/1ns
module set_once_bit (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic set_req,
	output logic      q
);
	logic q_reg;
	logic q_next;

	always_comb begin
		q_next = q_reg | set_req;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			q_reg <= 1'b0;
		end else begin
			q_reg <= q_next;
		end
	end

	assign q = q_reg;
endmodule : set_once_bit

/* File: sim/cpu_model_config_regs_tb_top.sv */
// self-checking bench for the model-specific configuration register group
// assumes the design carries its own assertions; bench drives every input directly
`timescale 1ns/1ns
module cpu_model_config_regs_tb_top;
	import cfg_regs_pkg::*;

	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam logic [63:0] CAP = 64'h0000_0000_0000_0A5A; // arbitrary capability word
	logic        clk;
	logic        reset;
	reg_req_t    req;
	ident_req_t  ident;
	logic        update_loaded;
	logic [31:0] update_signature_in;
	reg_rsp_t    rsp;
	logic        update_load_start;
	logic [2:0]  bus_speed;
	logic        serial_number_disable;
	int          num_errors = 0;
	int          cmp_count  = 0;
	int          cycles     = 0;

	cpu_model_config_regs #(.RANGE_CAP_VALUE(CAP)) u_dut (
		.clk                   (clk),
		.reset                 (reset),
		.req                   (req),
		.ident                 (ident),
		.update_loaded         (update_loaded),
		.update_signature_in   (update_signature_in),
		.rsp                   (rsp),
		.update_load_start     (update_load_start),
		.bus_speed             (bus_speed),
		.serial_number_disable (serial_number_disable)
	);

	// ----------------------------------------
	// clock, watchdog and tasks
	// ----------------------------------------
	always #4 clk = ~clk;

	// whole run is well under 200 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			end_sim();
		end
	end

	task end_sim;
		$display("errors %0d, comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim

	task chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// one request, returns 1 ns after the taking edge so registered effects are settled
	task acc(input logic w, input logic [ADDR_W-1:0] a, input logic [63:0] d);
		@(posedge clk);
		req <= '{1'b1, w, a, d};
		@(posedge clk);
		req.valid <= 1'b0;
		#1;
	endtask : acc

	task rd(input logic [ADDR_W-1:0] a, input logic [63:0] exp);
		acc(1'b0, a, ZERO64);
		chk(64'(rsp.valid), 64'h1);
		chk(rsp.rdata, exp);
	endtask : rd

	// identification, then a signature read taken on the very next edge
	task idf(input logic [31:0] a, input logic ld, input logic [31:0] s, input logic [63:0] exp);
		@(posedge clk);
		ident <= '{1'b1, a};
		update_loaded <= ld;
		update_signature_in <= s;
		@(posedge clk);
		ident.valid <= 1'b0;
		req <= '{1'b1, 1'b0, ADDR_UPD_SIG, ZERO64};
		@(posedge clk);
		req.valid <= 1'b0;
		#1;
		chk(64'(rsp.valid), 64'h1);
		chk(rsp.rdata, exp);
	endtask : idf

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		req = '0;
		ident = '0;
		update_loaded = 1'b0;
		update_signature_in = 32'h0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		#1;
		chk(64'(bus_speed), 64'h0);
		chk(64'(serial_number_disable), 64'h0);
		rd(ADDR_FREQ_CFG, ZERO64);
		rd(ADDR_UPD_SIG, ZERO64);
		acc(1'b1, ADDR_FREQ_CFG, '1);
		chk(64'(bus_speed), 64'h7);
		rd(ADDR_FREQ_CFG, 64'h0000_0000_00E0_0000);
		acc(1'b1, ADDR_FREQ_CFG, ZERO64);
		chk(64'(bus_speed), 64'h0);
		acc(1'b1, ADDR_UPD_TRIG, '1);
		chk(64'(update_load_start), 64'h1);
		@(posedge clk);
		#1;
		chk(64'(update_load_start), 64'h0);
		acc(1'b1, ADDR_UPD_SIG, '1);
		rd(ADDR_UPD_SIG, 64'hFFFF_FFFF_0000_0000);
		acc(1'b1, ADDR_UPD_SIG, ZERO64);
		idf(IDENT_LEAF_ONE, 1'b1, 32'h1234_5678, 64'h1234_5678_0000_0000);
		rd(ADDR_UPD_SIG, 64'h1234_5678_0000_0000);
		idf(32'h2, 1'b1, 32'h0BAD_0001, 64'h1234_5678_0000_0000);
		rd(ADDR_UPD_SIG, 64'h1234_5678_0000_0000);
		idf(IDENT_LEAF_ONE, 1'b0, 32'h0BAD_0001, ZERO64);
		rd(ADDR_UPD_SIG, ZERO64);
		acc(1'b1, ADDR_RANGE_CAP, '1);
		rd(ADDR_RANGE_CAP, CAP);
		rd(12'h123, ZERO64);
		acc(1'b1, ADDR_MISC_CTL, '1);
		chk(64'(serial_number_disable), 64'h1);
		rd(ADDR_MISC_CTL, 64'h0000_0000_0020_0000);
		acc(1'b1, ADDR_MISC_CTL, ZERO64);
		chk(64'(serial_number_disable), 64'h1);
		rd(ADDR_MISC_CTL, 64'h0000_0000_0020_0000);
		acc(1'b1, ADDR_FREQ_CFG, '1);
		acc(1'b1, ADDR_UPD_SIG, '1);
		// a second reset is the only way back to clear
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		#1;
		chk(64'(serial_number_disable), 64'h0);
		chk(64'(bus_speed), 64'h0);
		rd(ADDR_UPD_SIG, ZERO64);
		end_sim();
	end
endmodule : cpu_model_config_regs_tb_top
